/* asir_adc_model.sv */
`timescale 1ns/10ps
module asir_adc_model (
  input  wire logic        start,
  input  wire logic [7:0]  frames,
  input  wire logic [23:0] base,
  input  wire logic        early_msb,
  input  wire logic        launch_rise,
  output logic             sclk,
  output logic             lrck,
  output logic             sdata,
  output logic             busy
);
  logic [23:0] word;
  int          idx;

  ////////////////////////////////////////////////////////////
  // Idle: bit clock parked low, LRCK high so a burst opens cleanly
  initial begin
    sclk  = 1'b0;
    lrck  = 1'b1;
    sdata = 1'b0;
    busy  = 1'b0;
  end

  // One bit period; data and LRCK move on the launch edge, half a period before capture
  task automatic bit_period(input logic ch, input logic b);
    sclk  = launch_rise;
    lrck  = ch;
    sdata = b;
    #200;
    sclk  = ~launch_rise;
    #200;
  endtask

  ////////////////////////////////////////////////////////////
  // Lead-in right bit has no left partner, so the receiver must drop it
  always @(posedge start) begin
    busy = 1'b1;
    #7;
    bit_period(1'b1, 1'b0);
    for (int k = 0; k < frames; k++) begin
      for (int ch = 0; ch < 2; ch++) begin
        word = base + 24'(k * 32'h0000_0401);
        word = (ch == 0) ? word : ~word;
        for (int p = 0; p < 32; p++) begin // LRCK held for 32 bit clocks
          idx = early_msb ? p : p - 1;
          bit_period(ch[0], (idx >= 0 && idx < 24) ? word[23 - idx] : 1'b0);
        end
      end
    end
    // Closing LRCK fall is what pushes the last frame
    bit_period(1'b0, 1'b0);
    sclk  = 1'b0;
    sdata = ~sdata;
    busy  = 1'b0;
  end
endmodule

/* asir_fifo_mem.sv */
`timescale 1ns/10ps
module asir_fifo_mem
  import asir_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 wr_en,
  input  wire logic [FIFO_AW-1:0]   wr_addr,
  input  wire logic [ENTRY_W-1:0]   wr_data,
  input  wire logic [FIFO_AW-1:0]   rd_addr,
  output logic      [ENTRY_W-1:0]   rd_data
);
  import asir_pkg::*;

  typedef struct packed {
    logic [31:0][ENTRY_W-1:0] cells;
    logic [ENTRY_W-1:0]       rd_data;
  } asir_mem_t;

  asir_mem_t st;
  asir_mem_t next_st;

  // Write bypass keeps the read word equal to the cell after this edge
  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.cells[wr_addr] = wr_data;
    end
    next_st.rd_data = next_st.cells[rd_addr];
  end

  // Sample storage needs no reset
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign rd_data = st.rd_data;

endmodule

/* asir_pkg.sv */
package asir_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_SETUP   = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h04;
  localparam logic [7:0] OFF_RAW     = 8'h08;
  localparam logic [7:0] OFF_MASKED  = 8'h0C;
  localparam logic [7:0] OFF_CLEAR   = 8'h10;
  localparam logic [7:0] OFF_DATA    = 8'h14;

  // Setup register layout and reset value
  localparam logic [11:0] SETUP_RESET = 12'h004;
  localparam int B_DMA_EN      = 11;
  localparam int B_MCLK_INV    = 10;
  localparam int B_CLK_SRC_HI  = 9;
  localparam int B_CLK_SRC_LO  = 8;
  localparam int B_DAT_SRC_HI  = 7;
  localparam int B_DAT_SRC_LO  = 6;
  localparam int B_PACKED      = 5;
  localparam int B_SCLK_IDLE   = 4;
  localparam int B_FIRST_VALID = 3;
  localparam int B_SCLK_EDGE   = 2;
  localparam int B_OSR_HI      = 1;
  localparam int B_OSR_LO      = 0;

  // Flag layout of raw, masked and clear registers
  localparam int F_NEXT     = 7;
  localparam int F_PUSH_ERR = 6;
  localparam int F_EMPTY    = 5;
  localparam int F_AEMPTY   = 4;
  localparam int F_HALF     = 3;
  localparam int F_AFULL    = 2;
  localparam int F_FULL     = 1;
  localparam int F_POP_ERR  = 0;

  // FIFO and sample geometry
  localparam int FIFO_AW  = 5;
  localparam int ENTRY_W  = 48;
  localparam int SAMPLE_W = 24;
  localparam logic [5:0] FIFO_DEPTH  = 6'h20;
  localparam logic [4:0] SAMPLE_BITS = 5'h18;
  localparam logic [4:0] SAMPLE_MSB  = 5'h17;
  localparam logic [4:0] LR_LAST     = 5'h1F;

  typedef enum logic [1:0] {CLK_OUT_UNIT, CLK_EXT_ADC, CLK_CONVERTER, CLK_OWN_GEN} asir_clk_src_t;
  typedef enum logic [1:0] {DAT_FRONT_END, DAT_EXT_ADC, DAT_CONVERTER, DAT_LOOPBACK} asir_dat_src_t;

  // Pins from outside the clock domain
  typedef struct packed {
    logic out_sclk;
    logic out_lrck;
    logic ext_sclk;
    logic ext_lrck;
    logic conv_sclk;
    logic conv_lrck;
    logic afe_sdata;
    logic ext_sdata;
    logic conv_sdata;
    logic output_loopback_data;
    logic mclk;
    logic bus_clk_on;
  } asir_pins_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asir_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asir_apb_rsp_t;

  // MCLK edges per half period of the generated SCLK
  function automatic logic [2:0] osr_half(input logic [1:0] osr);
    unique case (osr)
      2'h1:    osr_half = 3'h2;
      2'h2:    osr_half = 3'h4;
      default: osr_half = 3'h1;
    endcase
  endfunction

endpackage

/* asir_receiver.sv */
// Summary of operation
// - Setup bit 11 enables the DMA request while the FIFO holds data.
// - Setup bit 10 picks the MCLK edge that moves the generated SCLK.
// - Setup bits 9:8 route SCLK and LRCK from one of four sources.
// - Setup bits 7:6 route serial data from one of four sources.
// - Setup bit 5 selects two reads per entry or one packed read.
// - Setup bit 4 set stops the receive bit clock.
// - Setup bit 3 set captures the first bit after LRCK change as MSB.
// - Setup bit 2 picks capture edge, positive when set; resets to one.
// - Setup bits 1:0 set oversampling 128x, 256x, 512x, 128x.
// - Enable bits gate flags onto the interrupt; bit 7 never interrupts.
// - Raw flags: push error, empty, almost empty, half, almost full, full, pop error.
// - Push and pop error pulses are latched until software clears them.
// - Masked flags read back as raw flags AND enable bits.
// - Clear bits 6 and 0 drop the latched errors; level flags unaffected.
// - Data register gives packed word, or alternates left and right with next flag.
// - The bit clock stop is resynchronised to SCLK before gating it.
// - No interrupt while the bus clock is off.
// - Data source three fills the FIFO from the output unit loopback.
// - Unpacked mode splits each 48 bit entry, left first then right.
// - FIFO holds 32 entries of 48 bits, both channels in one entry.
// - Samples are 24 bits, short words zero filled in low bits.
// - Setup register is 12 bits, read and write, reset 0x04.
`timescale 1ns/10ps
module asir_receiver
  import asir_pkg::*;
#(
  parameter logic [5:0] ALMOST_EMPTY_LVL = 6'h04,
  parameter logic [5:0] HALF_FULL_LVL    = 6'h10,
  parameter logic [5:0] ALMOST_FULL_LVL  = 6'h1C
)
(
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire asir_pkg::asir_apb_req_t apb_req,
  output asir_pkg::asir_apb_rsp_t      apb_rsp,
  input  wire asir_pkg::asir_pins_t    pins,
  output logic                 irq,
  output logic                 dma_req,
  output logic                 gen_sclk,
  output logic                 gen_lrck
);
  import asir_pkg::*;

  typedef struct packed {
    asir_pins_t            sync1;
    asir_pins_t            sync2;
    logic                  mclk_prev;
    logic [2:0]            div_cnt;
    logic                  gen_sclk;
    logic                  gen_lrck;
    logic [4:0]            lr_cnt;
    logic                  sclk_run;
    logic                  sclk_prev;
    logic                  lrck_prev;
    logic [4:0]            bit_cnt;
    logic [SAMPLE_W-1:0]   shift;
    logic [SAMPLE_W-1:0]   left_hold;
    logic                  have_left;
    logic [11:0]           ctl;
    logic [7:0]            mask;
    logic                  push_err;
    logic                  pop_err;
    logic                  next_ch;
    logic [FIFO_AW-1:0]    wr_ptr;
    logic [FIFO_AW-1:0]    rd_ptr;
    logic [5:0]            count;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  irq;
    logic                  dma_req;
  } asir_state_t;

  asir_state_t          st;
  asir_state_t          next_st;
  logic                 sel_sclk;
  logic                 sel_lrck;
  logic                 sel_data;
  logic                 gated_sclk;
  logic                 cap_edge;
  logic                 mclk_edge;
  logic                 push_req;
  logic                 push_ok;
  logic                 pop_ok;
  logic                 push_err_p;
  logic                 pop_err_p;
  logic                 data_rd;
  logic [ENTRY_W-1:0]   push_word;
  logic [ENTRY_W-1:0]   rd_entry;
  logic [7:0]           raw_flags;
  logic                 wr_acc;
  logic                 setup_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_SETUP) || (a == OFF_IRQ_EN) || (a == OFF_RAW) ||
                (a == OFF_MASKED) || (a == OFF_CLEAR) || (a == OFF_DATA);
  endfunction

  // Packed keeps the top 14 bits of each channel; unpacked gives one 24-bit word
  function automatic logic [31:0] fmt_data(input logic [ENTRY_W-1:0] e, input logic packed_mode,
                                           input logic right);
    if (packed_mode) begin
      fmt_data = {e[47:34], 2'h0, e[23:10], 2'h0};
    end else if (right) begin
      fmt_data = {8'h00, e[SAMPLE_W-1:0]};
    end else begin
      fmt_data = {8'h00, e[ENTRY_W-1:SAMPLE_W]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source routing, after the pin synchronisers

  always_comb begin
    unique case (asir_clk_src_t'(st.ctl[B_CLK_SRC_HI:B_CLK_SRC_LO]))
      CLK_OUT_UNIT:  begin sel_sclk = st.sync2.out_sclk;  sel_lrck = st.sync2.out_lrck;  end
      CLK_EXT_ADC:   begin sel_sclk = st.sync2.ext_sclk;  sel_lrck = st.sync2.ext_lrck;  end
      CLK_CONVERTER: begin sel_sclk = st.sync2.conv_sclk; sel_lrck = st.sync2.conv_lrck; end
      CLK_OWN_GEN:   begin sel_sclk = st.gen_sclk;        sel_lrck = st.gen_lrck;        end
    endcase
    unique case (asir_dat_src_t'(st.ctl[B_DAT_SRC_HI:B_DAT_SRC_LO]))
      DAT_FRONT_END: sel_data = st.sync2.afe_sdata;
      DAT_EXT_ADC:   sel_data = st.sync2.ext_sdata;
      DAT_CONVERTER: sel_data = st.sync2.conv_sdata;
      DAT_LOOPBACK:  sel_data = st.sync2.output_loopback_data;
    endcase
  end

  // The gate only changes while SCLK is low, so the gated clock never slivers
  assign gated_sclk = sel_sclk & st.sclk_run;
  assign cap_edge   = st.ctl[B_SCLK_EDGE] ? (gated_sclk & ~st.sclk_prev)
                                          : (~gated_sclk & st.sclk_prev);
  assign mclk_edge  = st.ctl[B_MCLK_INV] ? (st.sync2.mclk & ~st.mclk_prev)
                                         : (~st.sync2.mclk & st.mclk_prev);

  // Bus phases
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign data_rd  = apb_req.psel & apb_req.penable & ~apb_req.pwrite & (apb_req.paddr == OFF_DATA);
  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  // Live FIFO flags plus latched errors
  always_comb begin
    raw_flags             = 8'h00;
    raw_flags[F_NEXT]     = st.next_ch;
    raw_flags[F_PUSH_ERR] = st.push_err;
    raw_flags[F_EMPTY]    = (st.count == 6'h00);
    raw_flags[F_AEMPTY]   = (st.count <= ALMOST_EMPTY_LVL);
    raw_flags[F_HALF]     = (st.count >= HALF_FULL_LVL);
    raw_flags[F_AFULL]    = (st.count >= ALMOST_FULL_LVL);
    raw_flags[F_FULL]     = (st.count == FIFO_DEPTH);
    raw_flags[F_POP_ERR]  = st.pop_err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st    = st;
    push_req   = 1'b0;
    push_ok    = 1'b0;
    pop_ok     = 1'b0;
    push_err_p = 1'b0;
    pop_err_p  = 1'b0;
    push_word  = {st.left_hold, st.shift};
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;

    // Internal SCLK and LRCK from MCLK; half period of osr/128 MCLK edges
    next_st.mclk_prev = st.sync2.mclk;
    if (mclk_edge) begin
      if (st.div_cnt >= osr_half(st.ctl[B_OSR_HI:B_OSR_LO]) - 3'h1) begin
        next_st.div_cnt  = 3'h0;
        next_st.gen_sclk = ~st.gen_sclk;
        if (st.gen_sclk) begin
          next_st.lr_cnt = st.lr_cnt + 5'h01;
          if (st.lr_cnt == LR_LAST) begin
            next_st.gen_lrck = ~st.gen_lrck;
          end
        end
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
      end
    end

    // Bit clock stop takes effect only in the SCLK low phase
    if (!sel_sclk) begin
      next_st.sclk_run = ~st.ctl[B_SCLK_IDLE];
    end
    next_st.sclk_prev = gated_sclk;

    // Serial capture, MSB first, short words leave low bits at zero
    if (cap_edge) begin
      if (sel_lrck != st.lrck_prev) begin
        next_st.lrck_prev = sel_lrck;
        if (!st.lrck_prev) begin
          next_st.left_hold = st.shift;
          next_st.have_left = 1'b1;
        end else if (st.have_left) begin
          push_req          = 1'b1;
          next_st.have_left = 1'b0;
        end
        next_st.shift = '0;
        if (st.ctl[B_FIRST_VALID]) begin
          next_st.shift[SAMPLE_MSB] = sel_data;
          next_st.bit_cnt           = 5'h01;
        end else begin
          next_st.bit_cnt = 5'h00;
        end
      end else if (st.bit_cnt < SAMPLE_BITS) begin
        next_st.shift[SAMPLE_MSB - st.bit_cnt] = sel_data;
        next_st.bit_cnt                        = st.bit_cnt + 5'h01;
      end
    end

    // Push side
    if (push_req) begin
      if (st.count == FIFO_DEPTH) begin
        push_err_p = 1'b1;
      end else begin
        push_ok        = 1'b1;
        next_st.wr_ptr = st.wr_ptr + 5'h01;
      end
    end

    // Pop side: unpacked reads pop only after the right channel
    if (data_rd) begin
      if (st.count == 6'h00) begin
        pop_err_p = 1'b1;
      end else if (st.ctl[B_PACKED] || st.next_ch) begin
        pop_ok          = 1'b1;
        next_st.next_ch = 1'b0;
        next_st.rd_ptr  = st.rd_ptr + 5'h01;
      end else begin
        next_st.next_ch = 1'b1;
      end
    end
    next_st.count = st.count + {5'h00, push_ok} - {5'h00, pop_ok};

    // Register writes
    if (wr_acc) begin
      unique case (apb_req.paddr)
        OFF_SETUP:  next_st.ctl  = apb_req.pwdata[11:0];
        OFF_IRQ_EN: next_st.mask = apb_req.pwdata[7:0];
        default:    next_st.ctl  = st.ctl;
      endcase
    end

    // Error latches: a new pulse beats a clear in the same cycle
    next_st.push_err = push_err_p | (st.push_err &
                       ~(wr_acc && apb_req.paddr == OFF_CLEAR && apb_req.pwdata[F_PUSH_ERR]));
    next_st.pop_err  = pop_err_p | (st.pop_err &
                       ~(wr_acc && apb_req.paddr == OFF_CLEAR && apb_req.pwdata[F_POP_ERR]));

    // Read data is taken in the setup phase and held through access
    if (setup_rd) begin
      unique case (apb_req.paddr)
        OFF_SETUP:  next_st.prdata = {20'h0_0000, st.ctl};
        OFF_IRQ_EN: next_st.prdata = {24'h00_0000, st.mask};
        OFF_RAW:    next_st.prdata = {24'h00_0000, raw_flags};
        OFF_MASKED: next_st.prdata = {24'h00_0000, raw_flags & st.mask};
        OFF_DATA:   next_st.prdata = (st.count == 6'h00) ? 32'h0000_0000
                                     : fmt_data(rd_entry, st.ctl[B_PACKED], st.next_ch);
        default:    next_st.prdata = 32'h0000_0000;
      endcase
    end
    // Error status is taken in every setup phase, so a write never shows a stale read error
    if (apb_req.psel && !apb_req.penable) begin
      next_st.pslverr = ~is_mapped(apb_req.paddr);
    end

    // Interrupt held low while the bus clock is reported off
    next_st.irq = st.sync2.bus_clk_on &
                  (|(raw_flags[F_PUSH_ERR:F_POP_ERR] & st.mask[F_PUSH_ERR:F_POP_ERR]));
    next_st.dma_req = next_st.ctl[B_DMA_EN] & (next_st.count != 6'h00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st     <= '0;
      st.ctl <= SETUP_RESET;
      st.lrck_prev <= 1'b1; // Start in the right channel so a lone first right word is dropped
    end else begin
      st <= next_st;
    end
  end

  // Entry storage
  asir_fifo_mem u_mem (
    .clk_sys (clk_sys),
    .wr_en   (push_ok),
    .wr_addr (st.wr_ptr),
    .wr_data (push_word),
    .rd_addr (next_st.rd_ptr),
    .rd_data (rd_entry)
  );

  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = st.pslverr & apb_req.psel & apb_req.penable;
  assign irq             = st.irq;
  assign dma_req         = st.dma_req;
  assign gen_sclk        = st.gen_sclk;
  assign gen_lrck        = st.gen_lrck;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  dma_gate_a: assert property (dma_req |-> st.ctl[B_DMA_EN] && st.count != 6'h00)
    else $error("dma request without enable or data");

  push_err_hold_a: assert property (st.push_err && !(wr_acc && apb_req.paddr == OFF_CLEAR) |=> st.push_err)
    else $error("push error dropped without clear");

  masked_read_a: assert property (setup_rd && apb_req.paddr == OFF_MASKED
                                  |=> apb_rsp.prdata[7:0] == $past(raw_flags & st.mask))
    else $error("masked flags differ from raw and mask");

  pop_err_clr_a: assert property (wr_acc && apb_req.paddr == OFF_CLEAR && apb_req.pwdata[F_POP_ERR]
                                  && !pop_err_p |=> !st.pop_err)
    else $error("pop error not cleared");

  irq_bus_off_a: assert property (!st.sync2.bus_clk_on |=> !irq)
    else $error("interrupt while bus clock off");

  irq_cause_a: assert property (irq |-> $past(|(raw_flags[F_PUSH_ERR:F_POP_ERR] & st.mask[F_PUSH_ERR:F_POP_ERR])))
    else $error("interrupt without enabled flag");

  left_first_a: assert property (data_rd && !st.ctl[B_PACKED] && !st.next_ch && st.count != 6'h00
                                 |=> st.next_ch && st.count == $past(st.count) + {5'h00, $past(push_ok)})
    else $error("left read did not advance to right");

  packed_pop_a: assert property (data_rd && st.ctl[B_PACKED] && st.count != 6'h00
                                 |=> st.count == $past(st.count) + {5'h00, $past(push_ok)} - 6'h01)
    else $error("packed read did not pop");

  fifo_bound_a: assert property (st.count <= FIFO_DEPTH)
    else $error("fifo count beyond depth");

  sclk_gate_a: assert property ($changed(st.sclk_run) |-> !$past(sel_sclk))
    else $error("bit clock gate changed while high");

  lrck_period_a: assert property ($changed(gen_lrck) |-> $past(st.lr_cnt) == LR_LAST && $fell(gen_sclk))
    else $error("generated lrck period wrong");

endmodule

/* audio_serial_input_receiver_test.sv */
`timescale 1ns/10ps
module audio_serial_input_receiver_test;
  import asir_pkg::*;
  logic          clk_sys;
  logic          reset_n;
  logic          mclk;
  logic          bus_on;
  asir_apb_req_t req;
  asir_apb_rsp_t rsp;
  asir_pins_t    pins;
  logic          irq;
  logic          dma_req;
  logic          gen_sclk;
  logic          gen_lrck;
  logic          start;
  logic [7:0]    frames;
  logic [23:0]   base;
  logic          early;
  logic          rise;
  logic          sck;
  logic          lrc;
  logic          sd;
  logic          busy;
  logic [31:0]   q;
  logic          se;
  int            err_total = 0;
  int            check_count = 0;
  int            cycles = 0;

  ////////////////////////////////////////////////////////////
  // Bus clock 50 ns; master clock 800 ns, edges land on bus clock falling edges
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  initial mclk = 1'b0;
  always #400 mclk = ~mclk;

  asir_receiver uut (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .apb_req  (req),
    .apb_rsp  (rsp),
    .pins     (pins),
    .irq      (irq),
    .dma_req  (dma_req),
    .gen_sclk (gen_sclk),
    .gen_lrck (gen_lrck)
  );

  asir_adc_model adc (
    .start       (start),
    .frames      (frames),
    .base        (base),
    .early_msb   (early),
    .launch_rise (rise),
    .sclk        (sck),
    .lrck        (lrc),
    .sdata       (sd),
    .busy        (busy)
  );

  // Every source slot hears the same partner, so each legal pair carries real data
  assign pins = {sck, lrc, sck, lrc, sck, lrc, sd, sd, sd, sd, mclk, bus_on};

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Setup then access; the answer is taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    se = rsp.pslverr;
    req <= '0;
  endtask

  // Expected raw flags for a FIFO count and the latched errors
  function automatic logic [31:0] flg(input int n, input logic pu, input logic po, input logic nx);
    return {24'h00_0000, nx, pu, n == 0, n <= 4, n >= 16, n >= 28, n == 32, po};
  endfunction

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  // Covers the two-flop pin sync plus the registered output
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  // Bursts of frames from the partner; the settle margin covers synchroniser lag
  task automatic send(input int n, input logic [23:0] b, input logic e, input logic r);
    frames <= 8'(n);
    base <= b;
    early <= e;
    rise <= r;
    start <= 1'b1;
    wait (busy);
    start <= 1'b0;
    wait (!busy);
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic wait_tog(output int n);
    logic prev;
    prev = gen_sclk;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (gen_sclk === prev && n < 200);
  endtask

  // Counts generated SCLK toggles until the generated LRCK moves
  task automatic wait_lr(output int n);
    logic prev;
    logic sprev;
    prev = gen_lrck;
    sprev = gen_sclk;
    n = 0;
    do begin
      @(negedge clk_sys);
      if (gen_sclk !== sprev) n++;
      sprev = gen_sclk;
    end while (gen_lrck === prev && n < 200);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset();
    apb(0, OFF_SETUP, 0);
    chk(q, 32'h0000_0004);
    apb(0, OFF_RAW, 0);
    chk(q, flg(0, 0, 0, 0));
    apb(0, OFF_MASKED, 0);
    chk(q, 32'h0000_0000);
    apb(0, 8'h18, 0);
    chk(se, 1'b1);
    apb(1, OFF_SETUP, 32'hFFFF_FF6F);
    chk(se, 1'b0); // Mapped write after an unmapped read
    apb(0, OFF_SETUP, 0);
    chk(q, 32'h0000_0F6F);
    apb(1, OFF_RAW, 32'h0000_00FF);
    apb(0, OFF_RAW, 0);
    chk(q, flg(0, 0, 0, 0));
    apb(1, OFF_IRQ_EN, 32'h0000_00FF);
    settle();
    chk(irq, 1'b1);
    apb(1, OFF_IRQ_EN, 32'h0000_008F);
    settle();
    chk(irq, 1'b0);
  endtask

  task automatic t_unpacked();
    logic [23:0] l;
    do_reset();
    apb(1, OFF_SETUP, 32'h0000_0844); // External data, output unit clock
    send(3, 24'hA5_1234, 0, 0);
    settle();
    chk(dma_req, 1'b1);
    apb(1, OFF_SETUP, 32'h0000_0044);
    settle();
    chk(dma_req, 1'b0);
    apb(1, OFF_SETUP, 32'h0000_0844);
    for (int k = 0; k < 3; k++) begin
      l = 24'hA5_1234 + 24'(k * 32'h0000_0401);
      apb(0, OFF_DATA, 0); // Same address for every pop
      chk(q, {8'h00, l});
      apb(0, OFF_RAW, 0);
      chk(q, flg(3 - k, 0, 0, 1));
      apb(0, OFF_DATA, 0);
      chk(q, {8'h00, ~l});
    end
    settle();
    chk(dma_req, 1'b0);
  endtask

  task automatic t_packed();
    logic [23:0] l;
    logic [23:0] r;
    do_reset();
    apb(1, OFF_SETUP, 32'h0000_02A8); // Converter data and clock
    send(2, 24'h9E_3C71, 1, 1);
    for (int k = 0; k < 2; k++) begin
      l = 24'h9E_3C71 + 24'(k * 32'h0000_0401);
      r = ~l;
      apb(0, OFF_DATA, 0);
      chk(q, {l[23:10], 2'b00, r[23:10], 2'b00});
    end
    apb(0, OFF_DATA, 0);
    chk(q, 32'h0000_0000);
    apb(0, OFF_RAW, 0);
    chk(q, flg(0, 0, 1, 0));
    apb(1, OFF_CLEAR, 32'h0000_0001);
    apb(0, OFF_RAW, 0);
    chk(q, flg(0, 0, 0, 0));
  endtask

  task automatic t_fill();
    logic [23:0] l;
    logic [23:0] r;
    do_reset();
    apb(1, OFF_SETUP, 32'h0000_00E4); // Loopback data
    apb(1, OFF_IRQ_EN, 32'h0000_0040);
    send(33, 24'h01_0000, 0, 0);
    apb(0, OFF_RAW, 0);
    chk(q, flg(32, 1, 0, 0));
    apb(0, OFF_MASKED, 0);
    chk(q, 32'h0000_0040);
    settle();
    chk(irq, 1'b1);
    @(posedge clk_sys);
    bus_on <= 1'b0;
    settle();
    chk(irq, 1'b0);
    @(posedge clk_sys);
    bus_on <= 1'b1;
    apb(1, OFF_CLEAR, 32'h0000_0041);
    settle();
    chk(irq, 1'b0);
    for (int k = 0; k < 32; k++) begin
      l = 24'h01_0000 + 24'(k * 32'h0000_0401);
      r = ~l;
      apb(0, OFF_DATA, 0);
      chk(q, {l[23:10], 2'b00, r[23:10], 2'b00});
      apb(0, OFF_RAW, 0);
      chk(q, flg(31 - k, 0, 0, 0));
    end
  endtask

  task automatic t_stop();
    do_reset();
    apb(1, OFF_SETUP, 32'h0000_0014);
    send(2, 24'h55_0F0F, 0, 0);
    apb(0, OFF_RAW, 0);
    chk(q, flg(0, 0, 0, 0));
    apb(1, OFF_SETUP, 32'h0000_0004);
    send(1, 24'h55_0F0F, 0, 0);
    apb(0, OFF_RAW, 0);
    chk(q, flg(1, 0, 0, 0));
  endtask

  task automatic t_genclk();
    int n;
    int h;
    do_reset();
    for (int osr = 0; osr < 4; osr++) begin
      h = (osr == 1) ? 2 : (osr == 2) ? 4 : 1;
      apb(1, OFF_SETUP, 32'h0000_0344 | (32'(osr) & 32'h0000_0002) << 9 | 32'(osr));
      wait_tog(n);
      wait_tog(n);
      wait_tog(n);
      chk(n, 16 * h);
      chk(mclk, 32'(osr) >> 1);
    end
    // Generated LRCK spans 32 full SCLK periods
    wait_lr(n);
    wait_lr(n);
    chk(n, 64);
  endtask

  ////////////////////////////////////////////////////////////
  // Cuts a hang short; the full run needs roughly 25k cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 32'h0000_EA60) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    req = '0;
    bus_on = 1'b1;
    start = 1'b0;
    frames = 8'h00;
    base = 24'h00_0000;
    early = 1'b0;
    rise = 1'b0;
    t_regs();
    t_unpacked();
    t_packed();
    t_fill();
    t_stop();
    t_genclk();
    report_and_stop();
  end
endmodule
